// [verilog/eis_top.sv]
// External request enable and sense selection with AXI4-Lite register slave
// Summary of operation
// - Pin request passes only while enabled
// - Enable register 16 bits, resets zero
// - Enable bit 15 always reads zero
// - Sense registers choose each pin's trigger condition
// - Sense change may set pending flag
// - Enabled pending flag raises interrupt request
// - High register pins 14..8, low pins 7..0
// - Sense 00 low, 01 fall, 10 rise, 11 both
// - High sense bits 15:14 read zero
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module eis_top (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [14:0] extRequestPinN,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [14:0] pinRequest,
  output logic irqOut
);
  localparam int N = eis_pkg::NUM_PINS;

  logic [15:0] requestEnable_ff;
  logic [15:0] senseHigh_ff;
  logic [15:0] senseLow_ff;
  logic [14:0] requestStatus_ff;
  logic [14:0] irqEnable_ff;
  logic [14:0] pinSync1_ff;
  logic [14:0] pinSync2_ff;
  logic [14:0] pinSync3_ff;
  logic [14:0] pinStable_ff;
  logic [14:0] pinRequest_ff;
  logic irqOut_ff;

  logic [4:0] awAddr_ff;
  logic awHeld_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic wHeld_ff;
  logic bValid_ff;
  logic [1:0] bResp_ff;
  logic rValid_ff;
  logic [31:0] rData_ff;
  logic [1:0] rResp_ff;
  // Ready outputs come from flops: high only while the matching channel can take an item
  logic awReady_ff;
  logic wReady_ff;
  logic arReady_ff;

  // Write path: address and data latched independently, applied once both are held
  wire awTake = s_axi_awvalid && awReady_ff;
  wire wTake = s_axi_wvalid && wReady_ff;
  wire doWrite = awHeld_ff && wHeld_ff && !bValid_ff;
  wire [15:0] wMask = {{8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};
  wire wrEnable = doWrite && (awAddr_ff == eis_pkg::OFF_REQUEST_ENABLE);
  wire wrSenseHigh = doWrite && (awAddr_ff == eis_pkg::OFF_SENSE_SELECT_HIGH);
  wire wrSenseLow = doWrite && (awAddr_ff == eis_pkg::OFF_SENSE_SELECT_LOW);
  wire wrClear = doWrite && (awAddr_ff == eis_pkg::OFF_STATUS_CLEAR);
  wire wrIrqEn = doWrite && (awAddr_ff == eis_pkg::OFF_IRQ_ENABLE);
  wire wrHit = wrEnable || wrSenseHigh || wrSenseLow || wrClear || wrIrqEn ||
    (awAddr_ff == eis_pkg::OFF_REQUEST_STATUS);
  wire [15:0] wVal = wData_ff[15:0];
  // Enable bit 15 and high sense bits 15:14 are stored as zero whatever software writes
  wire [15:0] nxt_requestEnable = ((requestEnable_ff & ~wMask) | (wVal & wMask)) &
    eis_pkg::ENABLE_MASK;
  wire [15:0] nxt_senseHigh = ((senseHigh_ff & ~wMask) | (wVal & wMask)) &
    eis_pkg::SENSE_HIGH_MASK;
  wire [15:0] nxt_senseLow = ((senseLow_ff & ~wMask) | (wVal & wMask)) &
    eis_pkg::SENSE_LOW_MASK;
  wire [14:0] clearBits = wrClear ? (wVal[14:0] & wMask[14:0]) : 15'h0000;
  wire [14:0] nxt_irqEnable = (irqEnable_ff & ~wMask[14:0]) | (wVal[14:0] & wMask[14:0]);

  // Read path
  wire arTake = s_axi_arvalid && arReady_ff;
  wire [15:0] rdMux =
    (s_axi_araddr == eis_pkg::OFF_REQUEST_ENABLE) ? requestEnable_ff :
    (s_axi_araddr == eis_pkg::OFF_SENSE_SELECT_HIGH) ? senseHigh_ff :
    (s_axi_araddr == eis_pkg::OFF_SENSE_SELECT_LOW) ? senseLow_ff :
    (s_axi_araddr == eis_pkg::OFF_REQUEST_STATUS) ? {1'b0, requestStatus_ff} :
    (s_axi_araddr == eis_pkg::OFF_IRQ_ENABLE) ? {1'b0, irqEnable_ff} : 16'h0000;
  wire rdHit = (s_axi_araddr == eis_pkg::OFF_REQUEST_ENABLE) ||
    (s_axi_araddr == eis_pkg::OFF_SENSE_SELECT_HIGH) ||
    (s_axi_araddr == eis_pkg::OFF_SENSE_SELECT_LOW) ||
    (s_axi_araddr == eis_pkg::OFF_REQUEST_STATUS) ||
    (s_axi_araddr == eis_pkg::OFF_STATUS_CLEAR) ||
    (s_axi_araddr == eis_pkg::OFF_IRQ_ENABLE);

  // Combined sense fields: pins 7..0 from the low register, 14..8 from the high
  wire [29:0] senseAll = {senseHigh_ff[13:0], senseLow_ff};
  wire [29:0] senseNext = {nxt_senseHigh[13:0], nxt_senseLow};
  // Any written field change may flag its pin, mirroring the documented side effect
  wire [29:0] senseWrNew = wrSenseHigh ? {senseNext[29:16], senseAll[15:0]} :
    wrSenseLow ? {senseAll[29:16], senseNext[15:0]} : senseAll;

  // Three-stage sampling; a change counts once stages two and three agree
  wire [14:0] pinAgree = ~(pinSync2_ff ^ pinSync3_ff);
  wire [14:0] nxt_pinStable = (pinStable_ff & ~pinAgree) | (pinSync3_ff & pinAgree);
  logic [14:0] detect;
  logic [14:0] senseChanged;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : gPin
      wire [1:0] sel = senseAll[2*i+1:2*i];
      wire rise = nxt_pinStable[i] && !pinStable_ff[i];
      wire fall = !nxt_pinStable[i] && pinStable_ff[i];
      assign detect[i] = (sel == eis_pkg::SENSE_LOW_LEVEL) ? !pinStable_ff[i] :
        (sel == eis_pkg::SENSE_FALL) ? fall :
        (sel == eis_pkg::SENSE_RISE) ? rise : (rise || fall);
      assign senseChanged[i] = senseWrNew[2*i+1:2*i] != sel;
    end
  endgenerate

  // Set wins over a simultaneous clear
  wire [14:0] nxt_status = (requestStatus_ff & ~clearBits) | detect | senseChanged;
  wire [14:0] nxt_pinRequest = requestStatus_ff & requestEnable_ff[14:0];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      // Stages start at the idle pin level so release of reset shows no false low
      pinSync1_ff <= 15'h7fff;
      pinSync2_ff <= 15'h7fff;
      pinSync3_ff <= 15'h7fff;
      // Pins idle high; starting stable high avoids a false low-level hit
      pinStable_ff <= 15'h7fff;
    end else begin
      pinSync1_ff <= extRequestPinN;
      pinSync2_ff <= pinSync1_ff;
      pinSync3_ff <= pinSync2_ff;
      pinStable_ff <= nxt_pinStable;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      requestEnable_ff <= eis_pkg::RESET_VAL;
      senseHigh_ff <= eis_pkg::RESET_VAL;
      senseLow_ff <= eis_pkg::RESET_VAL;
      irqEnable_ff <= 15'h0000;
    end else begin
      if (wrEnable) begin
        requestEnable_ff <= nxt_requestEnable;
      end
      if (wrSenseHigh) begin
        senseHigh_ff <= nxt_senseHigh;
      end
      if (wrSenseLow) begin
        senseLow_ff <= nxt_senseLow;
      end
      if (wrIrqEn) begin
        irqEnable_ff <= nxt_irqEnable;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      requestStatus_ff <= 15'h0000;
      pinRequest_ff <= 15'h0000;
      irqOut_ff <= 1'b0;
    end else begin
      requestStatus_ff <= nxt_status;
      pinRequest_ff <= nxt_pinRequest;
      irqOut_ff <= |(requestStatus_ff & irqEnable_ff);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      awAddr_ff <= 5'h00;
      awHeld_ff <= 1'b0;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
      wHeld_ff <= 1'b0;
      bValid_ff <= 1'b0;
      bResp_ff <= eis_pkg::RESP_OKAY;
    end else begin
      if (awTake) begin
        awAddr_ff <= s_axi_awaddr;
        awHeld_ff <= 1'b1;
      end
      if (wTake) begin
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
        wHeld_ff <= 1'b1;
      end
      if (doWrite) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        bValid_ff <= 1'b1;
        bResp_ff <= wrHit ? eis_pkg::RESP_OKAY : eis_pkg::RESP_SLVERR;
      end else if (bValid_ff && s_axi_bready) begin
        bValid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rValid_ff <= 1'b0;
      rData_ff <= 32'h0000_0000;
      rResp_ff <= eis_pkg::RESP_OKAY;
    end else begin
      if (arTake) begin
        rValid_ff <= 1'b1;
        rData_ff <= {16'h0000, rdMux};
        rResp_ff <= rdHit ? eis_pkg::RESP_OKAY : eis_pkg::RESP_SLVERR;
      end else if (rValid_ff && s_axi_rready) begin
        rValid_ff <= 1'b0;
      end
    end
  end

  // Each ready predicts next cycle's free state: no item held and no response pending
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      awReady_ff <= 1'b0;
      wReady_ff <= 1'b0;
      arReady_ff <= 1'b0;
    end else begin
      awReady_ff <= !awTake && !(awHeld_ff && !doWrite) && !doWrite &&
        !(bValid_ff && !s_axi_bready);
      wReady_ff <= !wTake && !(wHeld_ff && !doWrite) && !doWrite &&
        !(bValid_ff && !s_axi_bready);
      arReady_ff <= !arTake && !(rValid_ff && !s_axi_rready);
    end
  end

  assign s_axi_awready = awReady_ff;
  assign s_axi_wready = wReady_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;
  assign pinRequest = pinRequest_ff;
  assign irqOut = irqOut_ff;
endmodule
`default_nettype wire

// [verilog/eis_pkg.sv]
// Package: register map, field layout and sense encodings for the external request block
package eis_pkg;
  localparam int NUM_PINS = 15;
  localparam int REG_W = 16;
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_REQUEST_ENABLE = 5'h00;
  localparam logic [4:0] OFF_SENSE_SELECT_HIGH = 5'h04;
  localparam logic [4:0] OFF_SENSE_SELECT_LOW = 5'h08;
  localparam logic [4:0] OFF_REQUEST_STATUS = 5'h0c;
  localparam logic [4:0] OFF_STATUS_CLEAR = 5'h10;
  localparam logic [4:0] OFF_IRQ_ENABLE = 5'h14;
  localparam logic [15:0] ENABLE_MASK = 16'h7fff;
  localparam logic [15:0] SENSE_HIGH_MASK = 16'h3fff;
  localparam logic [15:0] SENSE_LOW_MASK = 16'hffff;
  localparam logic [15:0] RESET_VAL = 16'h0000;
  localparam int LOW_PINS = 8;
  localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
  localparam logic [1:0] SENSE_FALL = 2'h1;
  localparam logic [1:0] SENSE_RISE = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [dv/eis_pin_model.sv]
// External devices that drive the request pins
`timescale 1ns/1ps
`default_nettype none
module eis_pin_model (
  input wire logic clk_sys,
  input wire logic [14:0] assertLow,
  input wire logic slow,
  output logic [14:0] extRequestPinN
);
  logic [14:0] lag_ff;
  // A slow device reaches its pin one cycle late; released pins sit high
  always_ff @(posedge clk_sys) lag_ff <= ~assertLow;
  assign extRequestPinN = slow ? lag_ff : ~assertLow;
endmodule
`default_nettype wire

// [dv/eis_top_asserts.sv]
// Port checker for the external request block
`timescale 1ns/1ps
`default_nettype none
module eis_top_chk (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [14:0] pinRequest,
  input wire logic irqOut
);
  logic [4:0] rdAddr_ff;
  logic [14:0] enSeen_ff;
  wire wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Shadow of the enable register; assumes full-word writes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdAddr_ff <= 5'h00;
      enSeen_ff <= 15'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) rdAddr_ff <= s_axi_araddr;
      if (wrTake && s_axi_awaddr == eis_pkg::OFF_REQUEST_ENABLE) enSeen_ff <= s_axi_wdata[14:0];
    end
  end
  chk_req_gated:
    assert property ((pinRequest & ~(enSeen_ff | $past(enSeen_ff) | $past(enSeen_ff, 2)
      | $past(enSeen_ff, 3))) == 15'h0) else $error("request passed while disabled");
  chk_rst_quiet:
    assert property ($rose(resetn) |-> pinRequest == 15'h0 && !irqOut) else $error("reset");
  chk_en_top:
    assert property (s_axi_rvalid && rdAddr_ff == eis_pkg::OFF_REQUEST_ENABLE
      |-> !s_axi_rdata[15]) else $error("enable top bit set");
  chk_high_top:
    assert property (s_axi_rvalid && rdAddr_ff == eis_pkg::OFF_SENSE_SELECT_HIGH
      |-> s_axi_rdata[15:14] == 2'h0) else $error("sense top bits set");
  chk_rd_upper:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0) else $error("upper data");
  chk_ar_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
  chk_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read dropped");
  chk_b_after:
    assert property (wrTake |-> ##[1:2] s_axi_bvalid) else $error("no bvalid");
  chk_busy_refuse:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("busy");
  cover property ($rose(irqOut));
  cover property (s_axi_bvalid && s_axi_bresp == eis_pkg::RESP_SLVERR);
  cover property (pinRequest != 15'h0);
endmodule
bind eis_top eis_top_chk chk (.clk_sys, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pinRequest,
  .irqOut);
`default_nettype wire

// [dv/testbench.sv]
// Bench: register access, pin stimulus and closing report
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic slow = 1'b0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1;
  logic s_axi_rready = 1'b1;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic [4:0] s_axi_awaddr = 5'h00;
  logic [4:0] s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [14:0] pinLow = 15'h0;
  logic [14:0] extRequestPinN;
  logic [14:0] pinRequest;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irqOut;
  logic [1:0] s_axi_bresp;
  logic [1:0] s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  eis_pin_model pins (.clk_sys, .assertLow(pinLow), .slow, .extRequestPinN);
  eis_top dut (.clk_sys, .resetn, .extRequestPinN, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pinRequest, .irqOut);
  always #4 clk_sys = ~clk_sys;
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d,
                    input logic [1:0] er = eis_pkg::RESP_OKAY);
    bit awDone;
    bit wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // Each channel is released at the edge that takes it
    while (!(awDone && wDone)) begin
      @(posedge clk_sys);
      if (!awDone && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        awDone = 1'b1;
      end
      if (!wDone && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        wDone = 1'b1;
      end
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
    cmp({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] ev,
                    input logic [1:0] er = eis_pkg::RESP_OKAY);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    if (er === eis_pkg::RESP_OKAY) cmp(s_axi_rdata, ev);
    cmp({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 12; i += 4) rd(5'(i), 32'h0);
    cmp({31'h0, irqOut}, 32'h0);
    $display("test reset values done");
    wr(eis_pkg::OFF_SENSE_SELECT_HIGH, 16'hffff);
    wr(eis_pkg::OFF_SENSE_SELECT_LOW, 16'hffff);
    rd(eis_pkg::OFF_SENSE_SELECT_HIGH, 32'h3fff);
    rd(eis_pkg::OFF_SENSE_SELECT_LOW, 32'hffff);
    rd(eis_pkg::OFF_REQUEST_STATUS, 32'h7fff);
    cmp({17'h0, pinRequest}, 32'h0);
    wr(eis_pkg::OFF_REQUEST_ENABLE, 16'hffff);
    rd(eis_pkg::OFF_REQUEST_ENABLE, 32'h7fff);
    cmp({17'h0, pinRequest}, 32'h7fff);
    $display("test sense change done");
    // Disable, reprogram, clear, re-enable: pins 0..3 take the four modes
    wr(eis_pkg::OFF_REQUEST_ENABLE, 16'h0000);
    wr(eis_pkg::OFF_SENSE_SELECT_LOW, 16'h00e4);
    wr(eis_pkg::OFF_SENSE_SELECT_HIGH, 16'h0000);
    wr(eis_pkg::OFF_STATUS_CLEAR, 16'h7fff);
    rd(eis_pkg::OFF_REQUEST_STATUS, 32'h0);
    wr(eis_pkg::OFF_REQUEST_ENABLE, 16'h000f);
    pinLow <= 15'h000f;
    repeat (10) @(posedge clk_sys);
    rd(eis_pkg::OFF_REQUEST_STATUS, 32'h000b);
    wr(eis_pkg::OFF_STATUS_CLEAR, 16'h000f);
    pinLow <= 15'h0;
    repeat (10) @(posedge clk_sys);
    rd(eis_pkg::OFF_REQUEST_STATUS, 32'h000d);
    tick();
    cmp({17'h0, pinRequest}, 32'h000d);
    wr(eis_pkg::OFF_REQUEST_ENABLE, 16'h0005);
    repeat (3) tick();
    cmp({17'h0, pinRequest}, 32'h0005);
    wr(eis_pkg::OFF_STATUS_CLEAR, 16'h000f);
    rd(eis_pkg::OFF_REQUEST_STATUS, 32'h0);
    $display("test sense modes done");
    slow <= 1'b1;
    wr(eis_pkg::OFF_REQUEST_ENABLE, 16'h0008);
    wr(eis_pkg::OFF_IRQ_ENABLE, 16'h0008);
    pinLow <= 15'h0008;
    repeat (12) tick();
    cmp({31'h0, irqOut}, 32'h1);
    wr(eis_pkg::OFF_IRQ_ENABLE, 16'h0000);
    repeat (3) tick();
    cmp({31'h0, irqOut}, 32'h0);
    wr(eis_pkg::OFF_IRQ_ENABLE, 16'h0008);
    wr(eis_pkg::OFF_STATUS_CLEAR, 16'h0008);
    repeat (3) tick();
    cmp({31'h0, irqOut}, 32'h0);
    wr(5'h18, 16'h0001, eis_pkg::RESP_SLVERR);
    rd(5'h1c, 32'h0, eis_pkg::RESP_SLVERR);
    $display("test interrupt and errors done");
    end_of_test();
  end
endmodule
`default_nettype wire
